// >>> pdc_host_model.sv
// host model: I/O read and write cycles on the device pins
// assumes the device answers each access with a pulse on IO_WAIT
`timescale 1ns/1ps
module pdc_host_model (
  input  wire logic       CLK,
  input  wire logic       IO_WAIT,
  input  wire logic [7:0] PERIPHERAL_DATA_BUS_OUT,
  output logic      [9:0] BUS_ADDR,
  output logic            IO_READ_STROBE_N,
  output logic            IO_WRITE_STROBE_N,
  output logic      [7:0] PERIPHERAL_DATA_BUS_IN
);
  initial begin
    BUS_ADDR = 10'h3ff;
    IO_READ_STROBE_N = 1'b1;
    IO_WRITE_STROBE_N = 1'b1;
    PERIPHERAL_DATA_BUS_IN = 8'h5a;
  end

  task automatic pins(input logic [9:0] a, input logic rd_n);
    @(posedge CLK);
    #5;
    BUS_ADDR = a;
    IO_READ_STROBE_N = rd_n;
  endtask

  // ---------------------------------------------------------------------
  // one access; waits is -1 if the wait count never ends
  // ---------------------------------------------------------------------
  task automatic access(input logic [9:0] a, input logic wr, input logic [7:0] d,
                        output logic [7:0] q, output int waits);
    int n;
    bit seen;
    waits = 0;
    seen = 1'b0;
    pins(a, 1'b1);
    PERIPHERAL_DATA_BUS_IN = d;
    pins(a, wr);
    IO_WRITE_STROBE_N = !wr;
    for (n = 0; n < 16; n++) begin
      @(posedge CLK);
      #5;
      if (IO_WAIT === 1'b1) begin
        waits++;
        seen = 1'b1;
      end else if (seen)
        break;
    end
    if (n == 16)
      waits = -1;
    q = PERIPHERAL_DATA_BUS_OUT;
    IO_READ_STROBE_N = 1'b1;
    IO_WRITE_STROBE_N = 1'b1;
    // released data never keeps the last value
    PERIPHERAL_DATA_BUS_IN = ~d;
    pins(10'h3ff, 1'b1);
    repeat (2) @(posedge CLK);
  endtask
endmodule // pdc_host_model

// >>> pdc_pkg.sv
// package for the peripheral decode and configuration block
// assumes one system clock domain; host I/O pins are asynchronous to it
// ---------------------------------------------------------------------
// Overview of operation
// - selects only with dack high, a9/a8 low
// - data bus driven on select plus read
// - eight selects; byte dma 000-00f, irq1 020-021
// - config 022-023, timer 040-043, clock 071 only
// - pages 080-08f, irq2 0a0-0a1, word dma 0c0-0df
// - index 01h at 22h, data at 23h
// - bits 7-6 register wait states, default four
// - register waits counted in system clocks
// - bits 5-4 word dma waits, default one
// - channel ready low at the last count stretches dma cycle
// - bits 3-2 byte dma waits, default one
// - bit 1 early dma memory read
// - bit 0 dma clock undivided, glitch-free switch
// ---------------------------------------------------------------------
package pdc_pkg;
  localparam logic [9:0] ADDR_BYTE_DMA  = 10'h000;
  localparam logic [9:0] ADDR_IRQ1      = 10'h020;
  localparam logic [9:0] ADDR_CFG_INDEX = 10'h022;
  localparam logic [9:0] ADDR_CFG_DATA  = 10'h023;
  localparam logic [9:0] ADDR_TIMER     = 10'h040;
  localparam logic [9:0] ADDR_CLOCK     = 10'h071;
  localparam logic [9:0] ADDR_PAGE      = 10'h080;
  localparam logic [9:0] ADDR_IRQ2      = 10'h0a0;
  localparam logic [9:0] ADDR_WORD_DMA  = 10'h0c0;
  localparam logic [7:0] CFG_INDEX_WAIT = 8'h01;
  localparam int REG_WAIT_LSB  = 6;
  localparam int WDMA_WAIT_LSB = 4;
  localparam int BDMA_WAIT_LSB = 2;
  localparam int EMR_BIT       = 1;
  localparam int DCLK_BIT      = 0;
  localparam logic [7:0] CFG_RESET   = 8'hc0;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam int SEL_BYTE_DMA = 0;
  localparam int SEL_IRQ1     = 1;
  localparam int SEL_CFG      = 2;
  localparam int SEL_TIMER    = 3;
  localparam int SEL_CLOCK    = 4;
  localparam int SEL_PAGE     = 5;
  localparam int SEL_IRQ2     = 6;
  localparam int SEL_WORD_DMA = 7;

  typedef struct packed {
    logic [1:0] reg_wait;
    logic [1:0] wdma_wait;
    logic [1:0] bdma_wait;
    logic       early_read;
    logic       dma_fast;
  } pdc_cfg_s;

  typedef enum logic [1:0] {WS_IDLE, WS_COUNT, WS_READY, WS_DONE} pdc_ws_e;
endpackage

// >>> pdc_top.sv
// top-level address decode and indexed configuration register
// assumes host strobes/address are asynchronous pins, synchronised here
`timescale 1ns/1ps
module pdc_top
  import pdc_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       DMA_ACK,
  input  wire logic [9:0] BUS_ADDR,
  input  wire logic       IO_READ_STROBE_N,
  input  wire logic       IO_WRITE_STROBE_N,
  input  wire logic [7:0] PERIPHERAL_DATA_BUS_IN,
  output logic      [7:0] PERIPHERAL_DATA_BUS_OUT,
  output logic            PERIPHERAL_DATA_BUS_OE_N,
  input  wire logic       CHANNEL_READY_IN,
  input  wire logic       DMA_CYCLE_START,
  input  wire logic       DMA_CYCLE_WORD,
  input  wire logic       BUS_MEMORY_READ_N,
  output logic            DMA_MEMORY_READ_N,
  output logic            BYTE_DMA_SELECT,
  output logic            FIRST_IRQ_CTRL_SELECT,
  output logic            CONFIG_SELECT,
  output logic            TIMER_SELECT,
  output logic            CLOCK_RAM_SELECT,
  output logic            PAGE_REGISTER_SELECT,
  output logic            SECOND_IRQ_CTRL_SELECT,
  output logic            WORD_DMA_SELECT,
  output logic            IO_WAIT,
  output logic            DMA_WAIT,
  output logic            DMA_DONE,
  output logic            DMA_CLOCK_EN,
  output logic            EARLY_MEM_READ_SELECT
);
  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [13:0] sync_a;
  logic [13:0] sync_b;
  logic        ack_s;
  logic [9:0]  addr_s;
  logic        rd_s;
  logic        wr_s;
  logic        rdy_s;
  logic        wr_d;
  logic        rd_d;
  logic [7:0]  din_a;
  logic [7:0]  din_s;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_a <= 14'h3000;
      sync_b <= 14'h3000;
      din_a  <= 8'h00;
      din_s  <= 8'h00;
    end else begin
      sync_a <= {IO_READ_STROBE_N, IO_WRITE_STROBE_N, CHANNEL_READY_IN, DMA_ACK, BUS_ADDR};
      sync_b <= sync_a;
      // data synced with the same latency as the strobes, settled one clock ahead
      din_a  <= PERIPHERAL_DATA_BUS_IN;
      din_s  <= din_a;
    end
  end

  assign addr_s = sync_b[9:0];
  assign ack_s  = sync_b[10];
  assign rdy_s  = sync_b[11];
  assign wr_s   = !sync_b[12];
  assign rd_s   = !sync_b[13];

  // -------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------
  logic       enable;
  logic [7:0] sel;

  // the dma acknowledge input is already active high at this pin
  assign enable = ack_s && !addr_s[9] && !addr_s[8];

  always_comb begin
    sel = 8'h00;
    if (enable) begin
      sel[SEL_BYTE_DMA] = addr_s[7:4] == ADDR_BYTE_DMA[7:4];
      sel[SEL_IRQ1]     = addr_s[7:1] == ADDR_IRQ1[7:1];
      sel[SEL_CFG]      = addr_s[7:1] == ADDR_CFG_INDEX[7:1];
      sel[SEL_TIMER]    = addr_s[7:2] == ADDR_TIMER[7:2];
      sel[SEL_CLOCK]    = addr_s[7:0] == ADDR_CLOCK[7:0];
      sel[SEL_PAGE]     = addr_s[7:4] == ADDR_PAGE[7:4];
      sel[SEL_IRQ2]     = addr_s[7:1] == ADDR_IRQ2[7:1];
      sel[SEL_WORD_DMA] = addr_s[7:5] == ADDR_WORD_DMA[7:5];
    end
  end

  assign BYTE_DMA_SELECT        = sel[SEL_BYTE_DMA];
  assign FIRST_IRQ_CTRL_SELECT  = sel[SEL_IRQ1];
  assign CONFIG_SELECT          = sel[SEL_CFG];
  assign TIMER_SELECT           = sel[SEL_TIMER];
  assign CLOCK_RAM_SELECT       = sel[SEL_CLOCK];
  assign PAGE_REGISTER_SELECT   = sel[SEL_PAGE];
  assign SECOND_IRQ_CTRL_SELECT = sel[SEL_IRQ2];
  assign WORD_DMA_SELECT        = sel[SEL_WORD_DMA];

  // -------------------------------------------------------------------
  // index and configuration registers
  // -------------------------------------------------------------------
  logic [7:0] index;
  logic [7:0] next_index;
  logic [7:0] cfg;
  logic [7:0] next_cfg;
  logic       wr_pulse;
  logic       rd_pulse;
  logic [7:0] rd_data;
  logic [7:0] next_rd_data;
  logic       is_data_port;

  assign wr_pulse     = wr_s && !wr_d;
  assign rd_pulse     = rd_s && !rd_d;
  assign is_data_port = addr_s[0] == ADDR_CFG_DATA[0];

  always_comb begin
    next_index   = index;
    next_cfg     = cfg;
    next_rd_data = rd_data;
    if (wr_pulse && sel[SEL_CFG]) begin
      if (!is_data_port) begin
        next_index = din_s;
      end else if (index == CFG_INDEX_WAIT) begin
        next_cfg = din_s;
      end
    end
    if (rd_pulse && sel[SEL_CFG]) begin
      if (!is_data_port) begin
        next_rd_data = index;
      end else begin
        next_rd_data = (index == CFG_INDEX_WAIT) ? cfg : 8'h00;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      index   <= INDEX_RESET;
      cfg     <= CFG_RESET;                  // four register waits, rest zero
      rd_data <= 8'h00;
      wr_d    <= 1'b0;
      rd_d    <= 1'b0;
    end else begin
      index   <= next_index;
      cfg     <= next_cfg;
      rd_data <= next_rd_data;
      wr_d    <= wr_s;
      rd_d    <= rd_s;
    end
  end

  pdc_cfg_s cfg_f;
  assign cfg_f = pdc_cfg_s'(cfg);

  // bus output: enabled on a read of any selected range; data is the last config port read
  assign PERIPHERAL_DATA_BUS_OUT  = rd_data;
  assign PERIPHERAL_DATA_BUS_OE_N = !((|sel) && rd_s);

  // -------------------------------------------------------------------
  // wait-state generators
  // -------------------------------------------------------------------
  logic io_start;
  logic io_busy;
  logic dma_busy;
  logic dma_start;

  assign io_start  = (rd_pulse || wr_pulse) && (|sel);
  assign dma_start = DMA_CYCLE_START && DMA_CLOCK_EN;

  pdc_wait_gen u_io_wait (
    .CLK       (CLK),
    .RST_B     (RST_B),
    .START     (io_start),
    .CODE      (cfg_f.reg_wait),
    .USE_READY (1'b0),
    .READY     (1'b1),
    .BUSY      (io_busy),
    .DONE      ()
  );

  pdc_wait_gen u_dma_wait (
    .CLK       (CLK),
    .RST_B     (RST_B),
    .START     (dma_start),
    .CODE      (DMA_CYCLE_WORD ? cfg_f.wdma_wait : cfg_f.bdma_wait),
    .USE_READY (1'b1),
    .READY     (rdy_s),
    .BUSY      (dma_busy),
    .DONE      (DMA_DONE)
  );

  assign IO_WAIT  = io_busy;
  assign DMA_WAIT = dma_busy;

  // -------------------------------------------------------------------
  // dma clock enable and early memory read
  // -------------------------------------------------------------------
  logic fast;
  logic next_fast;
  logic half;
  logic next_half;
  logic mr_d;
  logic next_mr_d;

  // switch rate only at a divided-clock boundary so no short dma clock
  always_comb begin
    next_half = !half;
    next_fast = fast;
    if (half) begin
      next_fast = cfg_f.dma_fast;
    end
    next_mr_d = BUS_MEMORY_READ_N;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      fast <= 1'b0;
      half <= 1'b0;
      mr_d <= 1'b1;
    end else begin
      fast <= next_fast;
      half <= next_half;
      mr_d <= next_mr_d;
    end
  end

  assign DMA_CLOCK_EN          = fast || half;
  assign EARLY_MEM_READ_SELECT = cfg_f.early_read;
  // late mode: release with bus, start one clock later
  assign DMA_MEMORY_READ_N = cfg_f.early_read ? BUS_MEMORY_READ_N
                                              : (BUS_MEMORY_READ_N || mr_d);

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  // decode ranges written from the address table, not from the decoder terms
  a_sel_gate: assert property (@(posedge CLK) disable iff (!RST_B)
    (!ack_s || addr_s[9] || addr_s[8]) |-> sel == 8'h00)
    else $error("select active while decoder disabled");
  a_sel_onehot: assert property (@(posedge CLK) disable iff (!RST_B)
    $onehot0(sel))
    else $error("more than one select");
  a_byte_dma_range: assert property (@(posedge CLK) disable iff (!RST_B)
    (enable && addr_s[7:4] == 4'h0) |-> sel[SEL_BYTE_DMA])
    else $error("byte dma range missed");
  a_irq1_pair: assert property (@(posedge CLK) disable iff (!RST_B)
    (enable && addr_s[7:1] == 7'h10) |-> sel[SEL_IRQ1])
    else $error("first irq pair missed");
  a_cfg_pair: assert property (@(posedge CLK) disable iff (!RST_B)
    (enable && addr_s[7:1] == 7'h11) |-> sel[SEL_CFG])
    else $error("config pair missed");
  a_timer_range: assert property (@(posedge CLK) disable iff (!RST_B)
    (enable && addr_s[7:2] == 6'h10) |-> sel[SEL_TIMER])
    else $error("timer range missed");
  a_clock_addr: assert property (@(posedge CLK) disable iff (!RST_B)
    sel[SEL_CLOCK] |-> addr_s[7:0] == 8'h71)
    else $error("clock select off its address");
  a_page_range: assert property (@(posedge CLK) disable iff (!RST_B)
    (enable && addr_s[7:4] == 4'h8) |-> sel[SEL_PAGE])
    else $error("page range missed");
  a_irq2_pair: assert property (@(posedge CLK) disable iff (!RST_B)
    (enable && addr_s[7:1] == 7'h50) |-> sel[SEL_IRQ2])
    else $error("second irq pair missed");
  a_word_dma_range: assert property (@(posedge CLK) disable iff (!RST_B)
    (enable && addr_s[7:5] == 3'h6) |-> sel[SEL_WORD_DMA])
    else $error("word dma range missed");

  // bus drive: both directions of the select-and-read gate
  a_drive_gate: assert property (@(posedge CLK) disable iff (!RST_B)
    !PERIPHERAL_DATA_BUS_OE_N |-> ((|sel) && rd_s))
    else $error("bus driven without select and read");
  a_drive_on_read: assert property (@(posedge CLK) disable iff (!RST_B)
    ((|sel) && rd_s) |-> !PERIPHERAL_DATA_BUS_OE_N)
    else $error("bus not driven on selected read");

  // index and data port behaviour
  a_cfg_write: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_pulse && sel[SEL_CFG] && is_data_port && index == 8'h01)
      |=> cfg == $past(din_s))
    else $error("config write lost");
  a_index_write: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_pulse && sel[SEL_CFG] && !is_data_port) |=> index == $past(din_s))
    else $error("index write lost");
  a_other_index: assert property (@(posedge CLK) disable iff (!RST_B)
    (wr_pulse && sel[SEL_CFG] && is_data_port && index != 8'h01) |=> cfg == $past(cfg))
    else $error("config changed through another index");

  // wait counts, dma clock and early read
  a_io_wait_len: assert property (@(posedge CLK) disable iff (!RST_B)
    (io_start && !io_busy && cfg_f.reg_wait == 2'h3) |=> io_busy [*4] ##1 !io_busy)
    else $error("register wait count wrong");
  a_io_wait_one: assert property (@(posedge CLK) disable iff (!RST_B)
    (io_start && !io_busy && cfg_f.reg_wait == 2'h0) |=> io_busy ##1 !io_busy)
    else $error("single register wait wrong");
  a_early_read: assert property (@(posedge CLK) disable iff (!RST_B)
    (!cfg_f.early_read && $fell(BUS_MEMORY_READ_N)) |-> DMA_MEMORY_READ_N)
    else $error("late dma read started early");
  a_fast_hold: assert property (@(posedge CLK) disable iff (!RST_B)
    (!half) |=> fast == $past(fast))
    else $error("dma clock switched mid-period");
  a_slow_rate: assert property (@(posedge CLK) disable iff (!RST_B)
    (!fast && !cfg_f.dma_fast && DMA_CLOCK_EN) |=> !DMA_CLOCK_EN)
    else $error("divided dma clock ran two in a row");
endmodule // pdc_top

// >>> pdc_wait_gen.sv
// wait-state counter for one bus cycle
// assumes start is a one-cycle pulse and ready is already synchronised
`timescale 1ns/1ps
module pdc_wait_gen
  import pdc_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       START,
  input  wire logic [1:0] CODE,
  input  wire logic       USE_READY,
  input  wire logic       READY,
  output logic            BUSY,
  output logic            DONE
);
  pdc_ws_e    state;
  pdc_ws_e    next_state;
  logic [2:0] count;
  logic [2:0] next_count;

  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      WS_IDLE: begin
        if (START) begin
          next_state = WS_COUNT;
          next_count = {1'b0, CODE} + 3'h1;   // code n gives n+1 waits
        end
      end
      WS_COUNT: begin
        next_count = count - 3'h1;           // counted in system clocks
        if (count == 3'h1) begin
          // ready only adds waits when it is low at the last count
          next_state = (USE_READY && !READY) ? WS_READY : WS_DONE;
        end
      end
      WS_READY: begin
        if (READY) begin
          next_state = WS_DONE;              // stretch while ready low
        end
      end
      WS_DONE: next_state = WS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= WS_IDLE;
      count <= 3'h0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign BUSY = (state == WS_COUNT) || (state == WS_READY);
  assign DONE = (state == WS_DONE);

  a_ready_holds: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == WS_READY && !READY) |=> state == WS_READY)
    else $error("wait ended while ready low");
  a_ready_no_extra: assert property (@(posedge CLK) disable iff (!RST_B)
    (state == WS_COUNT && count == 3'h1 && READY) |=> state == WS_DONE)
    else $error("extra wait with ready high");
endmodule // pdc_wait_gen

// >>> tb_pdc_top.sv
// testbench for the decode and configuration block
// assumes the host model drives all host pins
`timescale 1ns/1ps
module tb_pdc_top
  import pdc_pkg::*;
;
  logic       clk = 0, rst_b = 0, dma_ack = 1, rdy = 1, dstart = 0, dword = 0, bmr_n = 1;
  logic [9:0] addr;
  logic       rd_n, wr_n, oe_n, dmr_n, io_wait, dma_wait, dma_done, dclk_en, early_mem_read_select;
  logic [7:0] din, dout, sel, q;
  int         miscompares = 0, num_checks = 0, w, n, c, f, i;
  logic [9:0] ta [24] = '{10'h000, 10'h00f, 10'h010, 10'h020, 10'h021, 10'h022, 10'h023,
    10'h024, 10'h040, 10'h043, 10'h044, 10'h070, 10'h071, 10'h073, 10'h080, 10'h08f,
    10'h0a0, 10'h0a1, 10'h0a2, 10'h0c0, 10'h0df, 10'h0e0, 10'h100, 10'h200};
  int         ts [24] = '{0, 0, 8, 1, 1, 2, 2, 8, 3, 3, 8, 8, 4, 8, 5, 5, 6, 6, 8, 7, 7, 8, 8, 8};

  always #25 clk = ~clk;

  pdc_top i_dut (.CLK(clk), .RST_B(rst_b), .DMA_ACK(dma_ack), .BUS_ADDR(addr),
    .IO_READ_STROBE_N(rd_n), .IO_WRITE_STROBE_N(wr_n), .PERIPHERAL_DATA_BUS_IN(din),
    .PERIPHERAL_DATA_BUS_OUT(dout), .PERIPHERAL_DATA_BUS_OE_N(oe_n),
    .CHANNEL_READY_IN(rdy), .DMA_CYCLE_START(dstart), .DMA_CYCLE_WORD(dword),
    .BUS_MEMORY_READ_N(bmr_n), .DMA_MEMORY_READ_N(dmr_n), .BYTE_DMA_SELECT(sel[0]),
    .FIRST_IRQ_CTRL_SELECT(sel[1]), .CONFIG_SELECT(sel[2]), .TIMER_SELECT(sel[3]),
    .CLOCK_RAM_SELECT(sel[4]), .PAGE_REGISTER_SELECT(sel[5]),
    .SECOND_IRQ_CTRL_SELECT(sel[6]), .WORD_DMA_SELECT(sel[7]), .IO_WAIT(io_wait),
    .DMA_WAIT(dma_wait), .DMA_DONE(dma_done), .DMA_CLOCK_EN(dclk_en),
    .EARLY_MEM_READ_SELECT(early_mem_read_select));

  pdc_host_model i_host (.CLK(clk), .IO_WAIT(io_wait), .PERIPHERAL_DATA_BUS_OUT(dout),
    .BUS_ADDR(addr), .IO_READ_STROBE_N(rd_n), .IO_WRITE_STROBE_N(wr_n),
    .PERIPHERAL_DATA_BUS_IN(din));

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // counts from bounded waits; a negative one means the bound ran out
  task automatic chkn(input int got, input int exp, input string m);
    chk(got[7:0], exp[7:0], m);
    if (got < 0)
      stop_test();
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask

  task automatic cfg_write(input logic [7:0] v);
    i_host.access(ADDR_CFG_INDEX, 1'b1, CFG_INDEX_WAIT, q, w);
    i_host.access(ADDR_CFG_DATA, 1'b1, v, q, w);
    tick(1);
  endtask

  task automatic cfg_read(output logic [7:0] v);
    i_host.access(ADDR_CFG_INDEX, 1'b1, CFG_INDEX_WAIT, q, w);
    i_host.access(ADDR_CFG_DATA, 1'b0, 8'h00, v, w);
  endtask

  task automatic dma_run(input logic wd, input int lo, output int cnt);
    int k;
    // let a just-finished cycle return to idle before the next start
    tick(1);
    for (k = 0; k < 4 && dclk_en !== 1'b1; k++)
      tick(1);
    dstart = 1'b1;
    dword = wd;
    rdy = (lo == 0);
    tick(1);
    dstart = 1'b0;
    cnt = 0;
    for (k = 1; k < 60; k++) begin
      if (dma_wait === 1'b1)
        cnt++;
      if (dma_done === 1'b1)
        break;
      if (k == lo)
        rdy = 1'b1;
      tick(1);
    end
    if (k == 60)
      cnt = -1;
  endtask

  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    cfg_read(q);
    chk(q, CFG_RESET, "cfg reset");
    chk({7'h0, early_mem_read_select}, 8'h00, "emr reset");
    i_host.access(ADDR_CFG_INDEX, 1'b0, 8'h00, q, w);
    chk(q, CFG_INDEX_WAIT, "index read");
    $display("test reset done");
  endtask

  task automatic t_decode;
    for (i = 0; i < 24; i++) begin
      i_host.pins(ta[i], 1'b1);
      tick(3);
      chk(sel, ts[i] < 8 ? 8'h01 << ts[i] : 8'h00, "select");
      chk({7'h0, oe_n}, 8'h01, "oe no read");
    end
    i_host.pins(ADDR_TIMER, 1'b0);
    tick(3);
    chk({7'h0, oe_n}, 8'h00, "oe read");
    dma_ack = 1'b0;
    tick(3);
    chk(sel, 8'h00, "ack low");
    chk({7'h0, oe_n}, 8'h01, "oe ack low");
    dma_ack = 1'b1;
    i_host.pins(10'h030, 1'b0);
    tick(3);
    chk({7'h0, oe_n}, 8'h01, "oe unmapped");
    i_host.pins(10'h3ff, 1'b1);
    $display("test decode done");
  endtask

  task automatic t_index;
    cfg_write(8'h40);
    i_host.access(ADDR_CFG_INDEX, 1'b1, 8'h02, q, w);
    i_host.access(ADDR_CFG_DATA, 1'b1, 8'h55, q, w);
    i_host.access(ADDR_CFG_DATA, 1'b0, 8'h00, q, w);
    chk(q, 8'h00, "other index read");
    cfg_read(q);
    chk(q, 8'h40, "cfg kept");
    $display("test index done");
  endtask

  // the dma clock bit toggles too: waits must not depend on it
  task automatic t_regwait;
    for (c = 0; c < 4; c++) begin
      cfg_write({c[1:0], 5'h00, c[0]});
      i_host.access(ADDR_CFG_DATA, 1'b1, {c[1:0], 5'h00, c[0]}, q, w);
      chkn(w, c + 1, "io waits");
    end
    $display("test register waits done");
  endtask

  task automatic t_dma;
    for (f = 0; f < 2; f++)
      for (c = 0; c < 4; c++) begin
        cfg_write(f ? {2'b11, c[1:0], 4'h0} : {4'hc, c[1:0], 2'b00});
        dma_run(f[0], 0, n);
        chkn(n, c + 1, "dma waits");
      end
    dma_run(1'b1, 12, n);
    // ready released in pass 12, seen two sync stages later
    chkn(n, 12 + 2, "ready stretch");
    $display("test dma waits done");
  endtask

  task automatic t_emr;
    cfg_write(8'hc2);
    chk({7'h0, early_mem_read_select}, 8'h01, "emr set");
    bmr_n = 1'b0;
    #1 chk({7'h0, dmr_n}, 8'h00, "early read");
    tick(1);
    bmr_n = 1'b1;
    cfg_write(CFG_RESET);
    bmr_n = 1'b0;
    #1 chk({7'h0, dmr_n}, 8'h01, "late read held");
    tick(1);
    chk({7'h0, dmr_n}, 8'h00, "late read");
    bmr_n = 1'b1;
    $display("test early read done");
  endtask

  task automatic t_clk;
    for (f = 0; f < 2; f++) begin
      cfg_write({7'h60, f[0]});
      tick(4);
      n = 0;
      for (i = 0; i < 8; i++) begin
        n += (dclk_en === 1'b1);
        tick(1);
      end
      chkn(n, f ? 8 : 4, "dma clock rate");
    end
    $display("test dma clock done");
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #5;
    rst_b = 1'b1;
    tick(3);
    t_reset();
    t_decode();
    t_index();
    t_regwait();
    t_dma();
    t_emr();
    t_clk();
    stop_test();
  end
endmodule // tb_pdc_top
